/* design/spcs_pkg.sv */
// Notes on behaviour
// - receive-done flag set on accepted frame; only software write clears it.
// - transmit-done flag set when frame sent; only software write clears it.
// - serial interrupt request is receive-done OR transmit-done.
// - accepted frame stores ninth bit (modes 2,3) or stop bit (mode 1).
// - modes 2 and 3 transmit the stored transmit ninth bit.
// - no reception starts while receive enable is clear.
// - modes 2,3 with filter set accept only frames whose ninth bit is 1.
// - mode 1 with filter set discards frames whose stop bit is 0.
// - mode bits: 00 shift, 01 10-bit uart, 10/11 11-bit uart.
// - one data address: write loads transmit buffer, read returns receive buffer.
// - modes 1,3 transmit rate from timer 2 if select set, else timer 1.
// - modes 1,3 receive rate from timer 2 if select set, else timer 1.
// - timer 1 source halved when doubler clear, undivided when set.
// - mode 2 uses oscillator/2 with doubler set, oscillator/4 when clear.
// - missing stop bit in uart modes sets line error, filter notwithstanding.
// - accepted frame arriving in uart modes while buffer full sets line error.
// - line error is one combined flag, no interrupt, software clears only.
// - serial control register byte-addressable and bit-addressable.
// - timer 2 select bits sit in timer2 control, bit addresses consecutive.
// - baud doubler is bit 7 of power control, byte access only.
package spcs_pkg;
	localparam logic [7:0] SPCS_ADDR_SCTL = 8'h98;
	localparam logic [7:0] SPCS_ADDR_DBUF = 8'h99;
	localparam logic [7:0] SPCS_ADDR_PCTL = 8'h87;
	localparam logic [7:0] SPCS_ADDR_T2CTL = 8'hC8;
	localparam logic [7:0] SPCS_ADDR_IOCTL = 8'hF8;
	localparam logic [7:0] SPCS_BIT_SCTL_BASE = 8'h98;
	localparam logic [7:0] SPCS_BIT_TXSEL = 8'hCC;
	localparam logic [7:0] SPCS_BIT_RXSEL = 8'hCD;
	localparam logic [7:0] SPCS_BIT_LERR = 8'hFD;
	localparam int SPCS_POS_RXDONE = 0;
	localparam int SPCS_POS_TXDONE = 1;
	localparam int SPCS_POS_RX9 = 2;
	localparam int SPCS_POS_TX9 = 3;
	localparam int SPCS_POS_REN = 4;
	localparam int SPCS_POS_MPF = 5;
	localparam int SPCS_POS_TXSEL = 4;
	localparam int SPCS_POS_RXSEL = 5;
	localparam int SPCS_POS_DBL = 7;
	localparam int SPCS_POS_LERR = 5;
	localparam logic [7:0] SPCS_RST_BYTE = 8'h00;
	localparam logic [1:0] SPCS_MODE_SHIFT = 2'h0;
	localparam logic [1:0] SPCS_MODE_U10 = 2'h1;
	localparam logic [1:0] SPCS_MODE_U11F = 2'h2;
	localparam logic [1:0] SPCS_MODE_U11V = 2'h3;
	localparam logic [3:0] SPCS_SHIFT_DIV = 4'hC;
	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic bit_val;
	} spcs_sfr_s;
	typedef struct packed {
		logic done;
		logic [7:0] data;
		logic ninth;
		logic stop_ok;
	} spcs_rxframe_s;
	typedef struct packed {
		logic mode_sel_hi;
		logic mode_sel_lo;
		logic multiproc_filter;
		logic rx_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_done_flag;
	} spcs_sctl_s;
endpackage

/* design/spcs_div2.sv */
module spcs_div2 (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// tick in and out
	input wire logic tick_in,
	output logic tick_out
);
	typedef struct packed {
		logic phase;
		logic tick;
	} spcs_div2_st_s;
	spcs_div2_st_s st_ff;
	spcs_div2_st_s nxt_st;
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = tick_in & st_ff.phase;
		if (tick_in) begin
			nxt_st.phase = ~st_ff.phase;
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign tick_out = st_ff.tick;
endmodule

/* design/spcs_baud_sel.sv */
module spcs_baud_sel (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// configuration
	input wire logic [1:0] mode_in,
	input wire logic timer2_sel_in,
	input wire logic baud_doubler_in,
	// candidate sources, one-cycle ticks
	input wire logic t1_half_in,
	input wire logic t1_full_in,
	input wire logic t2_ovf_in,
	input wire logic osc_half_in,
	input wire logic osc_quarter_in,
	input wire logic shift_in,
	// chosen tick
	output logic tick_out
);
	logic sel;
	always_comb begin
		sel = 1'b0;
		case (mode_in)
			spcs_pkg::SPCS_MODE_SHIFT: sel = shift_in;
			spcs_pkg::SPCS_MODE_U11F: sel = baud_doubler_in ? osc_half_in : osc_quarter_in;
			default: begin
				if (timer2_sel_in) begin
					sel = t2_ovf_in;
				end else begin
					sel = baud_doubler_in ? t1_full_in : t1_half_in;
				end
			end
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= sel;
		end
	end
endmodule

/* design/spcs_top.sv */
module spcs_top (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// special function register port
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic sfr_bit_wr_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_bit_val_in,
	output logic [7:0] sfr_rdata_out,
	output logic sfr_bit_rdata_out,
	// timing sources
	input wire logic osc_tick_in,
	input wire logic t1_ovf_in,
	input wire logic t2_ovf_in,
	// frame engine interface
	input wire logic rx_frame_done_in,
	input wire logic [7:0] rx_frame_data_in,
	input wire logic rx_frame_ninth_in,
	input wire logic rx_frame_stop_in,
	input wire logic tx_frame_done_in,
	output logic tx_load_out,
	output logic [7:0] tx_data_out,
	output logic tx_ninth_out,
	output logic [1:0] mode_out,
	output logic rx_start_ok_out,
	output logic rx_baud_tick_out,
	output logic tx_baud_tick_out,
	// interrupt request
	output logic serial_irq_out
);
	typedef struct packed {
		spcs_pkg::spcs_sctl_s sctl;
		logic [7:0] rx_buf;
		logic [7:0] tx_buf;
		logic tx_load;
		logic tx_timer2_select;
		logic rx_timer2_select;
		logic baud_doubler;
		logic line_error_flag;
		logic [7:0] rdata;
		logic bit_rdata;
		logic irq;
		logic rx_start_ok;
		logic [3:0] shift_cnt;
		logic shift_tick;
	} spcs_st_s;
	spcs_st_s st_ff;
	spcs_st_s nxt_st;
	spcs_pkg::spcs_sfr_s sfr;
	spcs_pkg::spcs_rxframe_s rxf;
	logic [1:0] mode;
	logic t1_half;
	logic osc_half;
	logic osc_quarter;
	logic rx_tick;
	logic tx_tick;
	logic accept;
	logic uart;
	logic [7:0] sctl_byte;
	assign sfr = '{wr: sfr_wr_in, rd: sfr_rd_in, bit_wr: sfr_bit_wr_in, addr: sfr_addr_in,
		wdata: sfr_wdata_in, bit_val: sfr_bit_val_in};
	assign rxf = '{done: rx_frame_done_in, data: rx_frame_data_in, ninth: rx_frame_ninth_in,
		stop_ok: rx_frame_stop_in};
	assign mode = {st_ff.sctl.mode_sel_hi, st_ff.sctl.mode_sel_lo};
	assign uart = (mode != spcs_pkg::SPCS_MODE_SHIFT);
	assign sctl_byte = st_ff.sctl;
	// one halver shared by both directions keeps rx and tx timer 1 ticks aligned
	spcs_div2 u_t1_div (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.tick_in(t1_ovf_in),
		.tick_out(t1_half)
	);
	spcs_div2 u_osc_div (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.tick_in(osc_tick_in),
		.tick_out(osc_half)
	);
	spcs_div2 u_osc_div2 (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.tick_in(osc_half),
		.tick_out(osc_quarter)
	);
	spcs_baud_sel u_rx_sel (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.mode_in(mode),
		.timer2_sel_in(st_ff.rx_timer2_select),
		.baud_doubler_in(st_ff.baud_doubler),
		.t1_half_in(t1_half),
		.t1_full_in(t1_ovf_in),
		.t2_ovf_in(t2_ovf_in),
		.osc_half_in(osc_half),
		.osc_quarter_in(osc_quarter),
		.shift_in(st_ff.shift_tick),
		.tick_out(rx_tick)
	);
	spcs_baud_sel u_tx_sel (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.mode_in(mode),
		.timer2_sel_in(st_ff.tx_timer2_select),
		.baud_doubler_in(st_ff.baud_doubler),
		.t1_half_in(t1_half),
		.t1_full_in(t1_ovf_in),
		.t2_ovf_in(t2_ovf_in),
		.osc_half_in(osc_half),
		.osc_quarter_in(osc_quarter),
		.shift_in(st_ff.shift_tick),
		.tick_out(tx_tick)
	);
	// filter decision for a finished frame
	always_comb begin
		accept = 1'b1;
		if (st_ff.sctl.multiproc_filter) begin
			if (mode == spcs_pkg::SPCS_MODE_U10) begin
				accept = rxf.stop_ok;
			end else if (mode[1]) begin
				accept = rxf.ninth;
			end
		end
	end
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tx_load = 1'b0;
		nxt_st.shift_tick = 1'b0;
		// fixed shift-mode rate from the oscillator tick
		if (osc_tick_in) begin
			if (st_ff.shift_cnt == spcs_pkg::SPCS_SHIFT_DIV - 4'h1) begin
				nxt_st.shift_cnt = 4'h0;
				nxt_st.shift_tick = 1'b1;
			end else begin
				nxt_st.shift_cnt = st_ff.shift_cnt + 4'h1;
			end
		end
		// software writes first so that hardware sets below win over a clear
		if (sfr.wr) begin
			if (sfr.addr == spcs_pkg::SPCS_ADDR_SCTL) begin
				nxt_st.sctl = sfr.wdata;
			end else if (sfr.addr == spcs_pkg::SPCS_ADDR_DBUF) begin
				nxt_st.tx_buf = sfr.wdata;
				nxt_st.tx_load = 1'b1;
			end else if (sfr.addr == spcs_pkg::SPCS_ADDR_T2CTL) begin
				nxt_st.tx_timer2_select = sfr.wdata[spcs_pkg::SPCS_POS_TXSEL];
				nxt_st.rx_timer2_select = sfr.wdata[spcs_pkg::SPCS_POS_RXSEL];
			end else if (sfr.addr == spcs_pkg::SPCS_ADDR_PCTL) begin
				nxt_st.baud_doubler = sfr.wdata[spcs_pkg::SPCS_POS_DBL];
			end else if (sfr.addr == spcs_pkg::SPCS_ADDR_IOCTL) begin
				nxt_st.line_error_flag = sfr.wdata[spcs_pkg::SPCS_POS_LERR];
			end
		end else if (sfr.bit_wr) begin
			if (sfr.addr[7:3] == spcs_pkg::SPCS_BIT_SCTL_BASE[7:3]) begin
				case (sfr.addr[2:0])
					3'h0: nxt_st.sctl.rx_done_flag = sfr.bit_val;
					3'h1: nxt_st.sctl.tx_done_flag = sfr.bit_val;
					3'h2: nxt_st.sctl.rx_ninth_bit = sfr.bit_val;
					3'h3: nxt_st.sctl.tx_ninth_bit = sfr.bit_val;
					3'h4: nxt_st.sctl.rx_enable = sfr.bit_val;
					3'h5: nxt_st.sctl.multiproc_filter = sfr.bit_val;
					3'h6: nxt_st.sctl.mode_sel_lo = sfr.bit_val;
					default: nxt_st.sctl.mode_sel_hi = sfr.bit_val;
				endcase
			end else if (sfr.addr == spcs_pkg::SPCS_BIT_TXSEL) begin
				nxt_st.tx_timer2_select = sfr.bit_val;
			end else if (sfr.addr == spcs_pkg::SPCS_BIT_RXSEL) begin
				nxt_st.rx_timer2_select = sfr.bit_val;
			end else if (sfr.addr == spcs_pkg::SPCS_BIT_LERR) begin
				nxt_st.line_error_flag = sfr.bit_val;
			end
		end
		// frame results; a frame only ends if a start was allowed
		if (rxf.done) begin
			if (uart && !rxf.stop_ok) begin
				nxt_st.line_error_flag = 1'b1;
			end
			if (accept) begin
				if (uart && st_ff.sctl.rx_done_flag) begin
					nxt_st.line_error_flag = 1'b1;
				end else begin
					nxt_st.rx_buf = rxf.data;
					nxt_st.sctl.rx_done_flag = 1'b1;
					if (mode == spcs_pkg::SPCS_MODE_U10) begin
						nxt_st.sctl.rx_ninth_bit = rxf.stop_ok;
					end else if (mode[1]) begin
						nxt_st.sctl.rx_ninth_bit = rxf.ninth;
					end
				end
			end
		end
		if (tx_frame_done_in) begin
			nxt_st.sctl.tx_done_flag = 1'b1;
		end
		nxt_st.irq = nxt_st.sctl.rx_done_flag | nxt_st.sctl.tx_done_flag;
		// mode 0 reception also waits for a cleared receive-done flag
		nxt_st.rx_start_ok = nxt_st.sctl.rx_enable
			& (uart | ~nxt_st.sctl.rx_done_flag);
		// read data
		nxt_st.rdata = 8'h00;
		if (sfr.addr == spcs_pkg::SPCS_ADDR_SCTL) begin
			nxt_st.rdata = sctl_byte;
		end else if (sfr.addr == spcs_pkg::SPCS_ADDR_DBUF) begin
			nxt_st.rdata = st_ff.rx_buf;
		end else if (sfr.addr == spcs_pkg::SPCS_ADDR_T2CTL) begin
			nxt_st.rdata[spcs_pkg::SPCS_POS_TXSEL] = st_ff.tx_timer2_select;
			nxt_st.rdata[spcs_pkg::SPCS_POS_RXSEL] = st_ff.rx_timer2_select;
		end else if (sfr.addr == spcs_pkg::SPCS_ADDR_PCTL) begin
			nxt_st.rdata[spcs_pkg::SPCS_POS_DBL] = st_ff.baud_doubler;
		end else if (sfr.addr == spcs_pkg::SPCS_ADDR_IOCTL) begin
			nxt_st.rdata[spcs_pkg::SPCS_POS_LERR] = st_ff.line_error_flag;
		end
		nxt_st.bit_rdata = 1'b0;
		if (sfr.addr[7:3] == spcs_pkg::SPCS_BIT_SCTL_BASE[7:3]) begin
			nxt_st.bit_rdata = sctl_byte[sfr.addr[2:0]];
		end else if (sfr.addr == spcs_pkg::SPCS_BIT_TXSEL) begin
			nxt_st.bit_rdata = st_ff.tx_timer2_select;
		end else if (sfr.addr == spcs_pkg::SPCS_BIT_RXSEL) begin
			nxt_st.bit_rdata = st_ff.rx_timer2_select;
		end else if (sfr.addr == spcs_pkg::SPCS_BIT_LERR) begin
			nxt_st.bit_rdata = st_ff.line_error_flag;
		end
	end
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign sfr_rdata_out = st_ff.rdata;
	assign sfr_bit_rdata_out = st_ff.bit_rdata;
	assign tx_load_out = st_ff.tx_load;
	assign tx_data_out = st_ff.tx_buf;
	assign tx_ninth_out = st_ff.sctl.tx_ninth_bit;
	assign mode_out = mode;
	assign rx_start_ok_out = st_ff.rx_start_ok;
	assign rx_baud_tick_out = rx_tick;
	assign tx_baud_tick_out = tx_tick;
	assign serial_irq_out = st_ff.irq;

	AST_RXDONE_SET: assert property (@(posedge clk_in) disable iff (reset_in)
		(rx_frame_done_in && accept && !st_ff.sctl.rx_done_flag) |=> st_ff.sctl.rx_done_flag)
		else $error("receive-done not set");
	AST_RXDONE_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_ff.sctl.rx_done_flag && !sfr_wr_in && !sfr_bit_wr_in) |=> st_ff.sctl.rx_done_flag)
		else $error("receive-done cleared by hardware");
	AST_TXDONE_SET: assert property (@(posedge clk_in) disable iff (reset_in)
		tx_frame_done_in |=> st_ff.sctl.tx_done_flag)
		else $error("transmit-done not set");
	AST_IRQ_OR: assert property (@(posedge clk_in) disable iff (reset_in)
		serial_irq_out == (st_ff.sctl.rx_done_flag | st_ff.sctl.tx_done_flag))
		else $error("irq not or of flags");
	AST_NO_START: assert property (@(posedge clk_in) disable iff (reset_in)
		!st_ff.sctl.rx_enable |-> !rx_start_ok_out)
		else $error("reception allowed while disabled");
	AST_FILTER11: assert property (@(posedge clk_in) disable iff (reset_in)
		(rx_frame_done_in && mode[1] && st_ff.sctl.multiproc_filter && !rx_frame_ninth_in
		&& !sfr_wr_in && !sfr_bit_wr_in) |=> $stable(st_ff.rx_buf) && $stable(st_ff.sctl.rx_ninth_bit))
		else $error("filtered frame changed buffer");
	AST_FRAMING: assert property (@(posedge clk_in) disable iff (reset_in)
		(rx_frame_done_in && uart && !rx_frame_stop_in) |=> st_ff.line_error_flag)
		else $error("framing error missed");
	AST_OVERRUN: assert property (@(posedge clk_in) disable iff (reset_in)
		(rx_frame_done_in && uart && accept && st_ff.sctl.rx_done_flag) |=> st_ff.line_error_flag
		&& $stable(st_ff.rx_buf))
		else $error("overrun missed");
	AST_TXLOAD: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_wr_in && sfr_addr_in == spcs_pkg::SPCS_ADDR_DBUF) |=> tx_load_out
		&& tx_data_out == $past(sfr_wdata_in))
		else $error("transmit buffer not loaded");
	AST_TXDONE_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_ff.sctl.tx_done_flag && !sfr_wr_in && !sfr_bit_wr_in) |=> st_ff.sctl.tx_done_flag)
		else $error("transmit-done cleared by hardware");
	AST_RX9_STOP: assert property (@(posedge clk_in) disable iff (reset_in)
		(rx_frame_done_in && mode == spcs_pkg::SPCS_MODE_U10 && accept && !st_ff.sctl.rx_done_flag)
		|=> st_ff.sctl.rx_ninth_bit == $past(rx_frame_stop_in))
		else $error("stop bit not stored");
	AST_RX9_NINTH: assert property (@(posedge clk_in) disable iff (reset_in)
		(rx_frame_done_in && mode[1] && accept && !st_ff.sctl.rx_done_flag)
		|=> st_ff.sctl.rx_ninth_bit == $past(rx_frame_ninth_in))
		else $error("ninth bit not stored");
	AST_TX9_STORE: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_wr_in && sfr_addr_in == spcs_pkg::SPCS_ADDR_SCTL)
		|=> tx_ninth_out == $past(sfr_wdata_in[spcs_pkg::SPCS_POS_TX9]))
		else $error("transmit ninth bit not presented");
	AST_FILTER10: assert property (@(posedge clk_in) disable iff (reset_in)
		(rx_frame_done_in && mode == spcs_pkg::SPCS_MODE_U10 && st_ff.sctl.multiproc_filter
		&& !rx_frame_stop_in && !sfr_wr_in && !sfr_bit_wr_in) |=> $stable(st_ff.rx_buf)
		&& $stable(st_ff.sctl.rx_done_flag) && $stable(st_ff.sctl.rx_ninth_bit))
		else $error("stopless frame changed buffer");
	AST_MODE_SEL: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_wr_in && sfr_addr_in == spcs_pkg::SPCS_ADDR_SCTL)
		|=> mode_out == $past(sfr_wdata_in[7:6]))
		else $error("mode bits not decoded");
	AST_BUF_READ: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_addr_in == spcs_pkg::SPCS_ADDR_DBUF) |=> sfr_rdata_out == $past(st_ff.rx_buf))
		else $error("receive buffer not read");
	AST_TX_T2: assert property (@(posedge clk_in) disable iff (reset_in)
		(mode[0] && st_ff.tx_timer2_select) |=> tx_baud_tick_out == $past(t2_ovf_in))
		else $error("transmit rate not from timer 2");
	AST_RX_T2: assert property (@(posedge clk_in) disable iff (reset_in)
		(mode[0] && st_ff.rx_timer2_select) |=> rx_baud_tick_out == $past(t2_ovf_in))
		else $error("receive rate not from timer 2");
	AST_RX_T1FULL: assert property (@(posedge clk_in) disable iff (reset_in)
		(mode[0] && !st_ff.rx_timer2_select && st_ff.baud_doubler)
		|=> rx_baud_tick_out == $past(t1_ovf_in))
		else $error("receive rate not undivided timer 1");
	AST_TX_T1HALF: assert property (@(posedge clk_in) disable iff (reset_in)
		(mode[0] && !st_ff.tx_timer2_select && !st_ff.baud_doubler)
		|=> tx_baud_tick_out == $past(t1_half))
		else $error("transmit rate not halved timer 1");
	AST_OSC_HALF: assert property (@(posedge clk_in) disable iff (reset_in)
		(mode == spcs_pkg::SPCS_MODE_U11F && st_ff.baud_doubler) |=> rx_baud_tick_out == $past(osc_half))
		else $error("mode 2 rate not oscillator half");
	AST_OSC_QUARTER: assert property (@(posedge clk_in) disable iff (reset_in)
		(mode == spcs_pkg::SPCS_MODE_U11F && !st_ff.baud_doubler) |=> tx_baud_tick_out == $past(osc_quarter))
		else $error("mode 2 rate not oscillator quarter");
	AST_LERR_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
		(st_ff.line_error_flag && !sfr_wr_in && !sfr_bit_wr_in) |=> st_ff.line_error_flag)
		else $error("line error cleared by hardware");
	AST_SCTL_BYTE: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_wr_in && sfr_addr_in == spcs_pkg::SPCS_ADDR_SCTL && !rx_frame_done_in && !tx_frame_done_in)
		|=> sctl_byte == $past(sfr_wdata_in))
		else $error("control byte write lost");
	AST_SCTL_BIT: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_bit_wr_in && !sfr_wr_in && sfr_addr_in[7:3] == spcs_pkg::SPCS_BIT_SCTL_BASE[7:3]
		&& sfr_addr_in[2:0] == 3'h4) |=> st_ff.sctl.rx_enable == $past(sfr_bit_val_in))
		else $error("receive enable bit write lost");
	AST_TXSEL_BIT: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_bit_wr_in && !sfr_wr_in && sfr_addr_in == spcs_pkg::SPCS_BIT_TXSEL)
		|=> st_ff.tx_timer2_select == $past(sfr_bit_val_in))
		else $error("transmit select bit write lost");
	AST_RXSEL_BIT: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_bit_wr_in && !sfr_wr_in && sfr_addr_in == spcs_pkg::SPCS_BIT_RXSEL)
		|=> st_ff.rx_timer2_select == $past(sfr_bit_val_in))
		else $error("receive select bit write lost");
	AST_DBL_BYTE: assert property (@(posedge clk_in) disable iff (reset_in)
		(sfr_wr_in && sfr_addr_in == spcs_pkg::SPCS_ADDR_PCTL)
		|=> st_ff.baud_doubler == $past(sfr_wdata_in[spcs_pkg::SPCS_POS_DBL]))
		else $error("baud doubler write lost");
endmodule

/* verification/spcs_remote_model.sv */
module spcs_remote_model (
	// clock
	input wire logic clk_in,
	// device side
	input wire logic tx_load_in,
	input wire logic rx_start_ok_in,
	output logic rx_frame_done_out,
	output logic [7:0] rx_frame_data_out,
	output logic rx_frame_ninth_out,
	output logic rx_frame_stop_out,
	output logic tx_frame_done_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int tx_wait = 12;
	initial begin
		rx_frame_done_out = 1'b0;
		rx_frame_data_out = 8'h00;
		rx_frame_ninth_out = 1'b0;
		rx_frame_stop_out = 1'b0;
		tx_frame_done_out = 1'b0;
	end
	// frame takes tx_wait cycles on the line
	always begin
		@(negedge clk_in);
		if (tx_load_in === 1'b1) begin
			repeat (tx_wait) @(negedge clk_in);
			tx_frame_done_out = 1'b1;
			@(negedge clk_in);
			tx_frame_done_out = 1'b0;
		end
	end
	// no frame begins unless the port allows it
	task send(input logic [7:0] d, input logic n, input logic s);
		@(negedge clk_in);
		if (rx_start_ok_in === 1'b1) begin
			rx_frame_done_out = 1'b1;
			rx_frame_data_out = d;
			rx_frame_ninth_out = n;
			rx_frame_stop_out = s;
			@(negedge clk_in);
			rx_frame_done_out = 1'b0;
			// stale fields inverted so nothing leans on held values
			rx_frame_data_out = ~d;
			rx_frame_ninth_out = ~n;
			rx_frame_stop_out = ~s;
		end
	endtask
endmodule

/* verification/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic sfr_wr_in = 1'b0;
	logic sfr_rd_in = 1'b0;
	logic sfr_bit_wr_in = 1'b0;
	logic [7:0] sfr_addr_in = 8'h00;
	logic [7:0] sfr_wdata_in = 8'h00;
	logic sfr_bit_val_in = 1'b0;
	logic [7:0] sfr_rdata_out;
	logic sfr_bit_rdata_out;
	logic osc_tick_in = 1'b0;
	logic t1_ovf_in = 1'b0;
	logic t2_ovf_in = 1'b0;
	logic rx_frame_done_in;
	logic [7:0] rx_frame_data_in;
	logic rx_frame_ninth_in;
	logic rx_frame_stop_in;
	logic tx_frame_done_in;
	logic tx_load_out;
	logic [7:0] tx_data_out;
	logic tx_ninth_out;
	logic [1:0] mode_out;
	logic rx_start_ok_out;
	logic rx_baud_tick_out;
	logic tx_baud_tick_out;
	logic serial_irq_out;
	logic src_on = 1'b0;
	int failures = 0;
	int samples_checked = 0;
	int cyc = 0;
	int rx_cnt = 0;
	int tx_cnt = 0;
	int r;
	int t;

	spcs_top spcs_top_i (.clk_in, .reset_in, .sfr_wr_in, .sfr_rd_in, .sfr_bit_wr_in, .sfr_addr_in,
		.sfr_wdata_in, .sfr_bit_val_in, .sfr_rdata_out, .sfr_bit_rdata_out, .osc_tick_in, .t1_ovf_in,
		.t2_ovf_in, .rx_frame_done_in, .rx_frame_data_in, .rx_frame_ninth_in, .rx_frame_stop_in,
		.tx_frame_done_in, .tx_load_out, .tx_data_out, .tx_ninth_out, .mode_out, .rx_start_ok_out,
		.rx_baud_tick_out, .tx_baud_tick_out, .serial_irq_out);
	spcs_remote_model spcs_remote_model_i (.clk_in(clk_in), .tx_load_in(tx_load_out),
		.rx_start_ok_in(rx_start_ok_out), .rx_frame_done_out(rx_frame_done_in),
		.rx_frame_data_out(rx_frame_data_in), .rx_frame_ninth_out(rx_frame_ninth_in),
		.rx_frame_stop_out(rx_frame_stop_in), .tx_frame_done_out(tx_frame_done_in));

	always #25 clk_in = ~clk_in;
	// t2 at a third of t1 so the two sources count apart
	always @(negedge clk_in) begin
		cyc++;
		osc_tick_in <= src_on;
		t1_ovf_in <= src_on;
		t2_ovf_in <= src_on && (cyc % 3 == 0);
		if (cyc > 20000) begin
			failures++;
			wrap_up();
		end
	end
	always @(posedge clk_in) begin
		rx_cnt += int'(rx_baud_tick_out);
		tx_cnt += int'(tx_baud_tick_out);
	end

	task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		sfr_wr_in = 1'b1;
		sfr_addr_in = a;
		sfr_wdata_in = d;
		@(negedge clk_in);
		sfr_wr_in = 1'b0;
	endtask
	task bwr(input logic [7:0] a, input logic v);
		@(negedge clk_in);
		sfr_bit_wr_in = 1'b1;
		sfr_addr_in = a;
		sfr_bit_val_in = v;
		@(negedge clk_in);
		sfr_bit_wr_in = 1'b0;
	endtask
	// read data lags the address by one cycle
	task expect_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_in);
		sfr_addr_in = a;
		@(negedge clk_in);
		check(sfr_rdata_out, exp, $sformatf("reg %h", a));
	endtask
	task expect_bit(input logic [7:0] a, input logic v);
		@(negedge clk_in);
		sfr_addr_in = a;
		@(negedge clk_in);
		check({7'h00, sfr_bit_rdata_out}, {7'h00, v}, $sformatf("bit %h", a));
	endtask
	// window a multiple of every period, so phase cannot shift the count
	task count_ticks(output int rc, output int tc);
		src_on = 1'b1;
		repeat (12) @(negedge clk_in);
		rx_cnt = 0;
		tx_cnt = 0;
		repeat (96) @(negedge clk_in);
		rc = rx_cnt;
		tc = tx_cnt;
		src_on = 1'b0;
	endtask

	task t_tx;
		int n;
		expect_reg(8'h80, 8'h00);
		wr(8'h99, 8'h5A);
		check({7'h00, tx_load_out}, 8'h01, "tx_load");
		check(tx_data_out, 8'h5A, "tx_data");
		n = 0;
		while (serial_irq_out !== 1'b1 && n < 50) begin
			@(negedge clk_in);
			n++;
		end
		expect_reg(8'h98, 8'h02);
		check({7'h00, serial_irq_out}, 8'h01, "irq");
		wr(8'h98, 8'h00);
		expect_reg(8'h98, 8'h00);
		check({7'h00, serial_irq_out}, 8'h00, "irq");
		$display("test tx finished");
	endtask
	task t_rx;
		wr(8'h98, 8'h50);
		spcs_remote_model_i.send(8'hA5, 1'b0, 1'b1);
		expect_reg(8'h98, 8'h55);
		expect_reg(8'h99, 8'hA5);
		check({7'h00, serial_irq_out}, 8'h01, "irq");
		spcs_remote_model_i.send(8'h3C, 1'b0, 1'b1);
		expect_reg(8'h99, 8'hA5);
		expect_reg(8'hF8, 8'h20);
		expect_bit(8'hFD, 1'b1);
		bwr(8'hFD, 1'b0);
		expect_reg(8'hF8, 8'h00);
		repeat (20) @(negedge clk_in);
		expect_reg(8'h98, 8'h55);
		$display("test rx finished");
	endtask
	task t_filter;
		wr(8'h98, 8'h70);
		spcs_remote_model_i.send(8'h11, 1'b0, 1'b0);
		expect_reg(8'h98, 8'h70);
		expect_reg(8'h99, 8'hA5);
		expect_reg(8'hF8, 8'h20);
		wr(8'hF8, 8'h00);
		wr(8'h98, 8'hF8);
		check({6'h00, mode_out}, 8'h03, "mode");
		check({7'h00, tx_ninth_out}, 8'h01, "tx_ninth");
		spcs_remote_model_i.send(8'h22, 1'b0, 1'b1);
		expect_reg(8'h98, 8'hF8);
		spcs_remote_model_i.send(8'h33, 1'b1, 1'b1);
		expect_reg(8'h98, 8'hFD);
		expect_reg(8'h99, 8'h33);
		$display("test filter finished");
	endtask
	task t_ren;
		wr(8'h98, 8'h40);
		check({7'h00, rx_start_ok_out}, 8'h00, "rx_start_ok");
		spcs_remote_model_i.send(8'h44, 1'b1, 1'b1);
		expect_reg(8'h98, 8'h40);
		bwr(8'h9C, 1'b1);
		expect_bit(8'h9C, 1'b1);
		expect_reg(8'h98, 8'h50);
		check({7'h00, rx_start_ok_out}, 8'h01, "rx_start_ok");
		$display("test enable finished");
	endtask
	task t_baud;
		wr(8'h98, 8'h40);
		bwr(8'hCC, 1'b1);
		expect_bit(8'hCC, 1'b1);
		expect_reg(8'hC8, 8'h10);
		wr(8'h87, 8'h00);
		count_ticks(r, t);
		check(r[7:0], 8'd48, "rx ticks");
		check(t[7:0], 8'd32, "tx ticks");
		bwr(8'hCD, 1'b1);
		wr(8'h87, 8'h80);
		expect_reg(8'h87, 8'h80);
		count_ticks(r, t);
		check(r[7:0], 8'd32, "rx ticks");
		bwr(8'hCD, 1'b0);
		count_ticks(r, t);
		check(r[7:0], 8'd96, "rx ticks");
		wr(8'h98, 8'h80);
		count_ticks(r, t);
		check(t[7:0], 8'd48, "tx ticks");
		wr(8'h87, 8'h00);
		count_ticks(r, t);
		check(r[7:0], 8'd24, "rx ticks");
		wr(8'h98, 8'h00);
		count_ticks(r, t);
		check(r[7:0], 8'd8, "rx ticks");
		$display("test baud finished");
	endtask

	task wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(negedge clk_in);
		reset_in = 1'b0;
		t_tx();
		t_rx();
		t_filter();
		t_ren();
		t_baud();
		wrap_up();
	end
endmodule
